/* verilog/diu_top.sv */
// diu_top: diagnostic interrupt generation and record holding for the field-bus master
// assumes host status, mode and fault inputs synchronous to CLK; host reads records by index
`timescale 1ns/10ps
module diu_top
    import diu_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HOST_STOP,
    input wire logic HOST_ACK,
    input wire logic PROT_MODE,
    input wire logic LINE_POWER_FAIL,
    input wire logic NVM_FAULT,
    input wire logic [DIU_SLAVES-1:0] SLAVE_MISSING,
    input wire logic [DIU_SLAVES-1:0] SLAVE_WRONG_TYPE,
    input wire logic [DIU_SLAVES-1:0] SLAVE_UNCONFIG,
    input wire logic [DIU_IDX_W-1:0] REC_INDEX,
    output logic DIAG_IRQ,
    output logic [7:0] REC_DATA,
    output logic [31:0] BASIC_DIAG_RECORD
);
    // observed total state
    logic [DIU_SLAVES-1:0] delta_now;
    logic cfg_err_now;
    logic pwr_now;
    logic ext_now;
    assign delta_now = SLAVE_MISSING | SLAVE_WRONG_TYPE | SLAVE_UNCONFIG;
    assign cfg_err_now = PROT_MODE && (|delta_now);
    assign pwr_now = PROT_MODE && LINE_POWER_FAIL;

    // state registers
    diu_state_t state_q, state_d;
    logic irq_q, irq_d;
    logic int_q, int_d; // latched internal fault
    logic prot_q, prot_d;
    logic [DIU_SLAVES-1:0] snap_delta_q, snap_delta_d;
    logic snap_pwr_q, snap_pwr_d;
    logic snap_int_q, snap_int_d;
    logic [DIU_SLAVES-1:0] rec_delta_q, rec_delta_d;
    logic rec_pwr_q, rec_pwr_d;
    logic rec_int_q, rec_int_d;
    logic rec_group_q, rec_group_d;
    logic [7:0] data_q, data_d;
    logic [31:0] basic_q, basic_d;

    logic [DIU_SLAVES-1:0] cur_delta;
    logic changed;
    logic can_signal;
    logic err_free;
    logic leave_prot;
    logic [DIU_SLAVES-1:0] base_delta;
    logic base_pwr;
    logic [7:0] b0, b2, b3;
    logic [31:0] basic_img;
    logic [7:0] ext_img [DIU_EXT_BYTES];

    always_comb begin
        cur_delta = PROT_MODE ? delta_now : '0;
        ext_now = cfg_err_now | pwr_now;
        leave_prot = prot_q && !PROT_MODE;
        // history drop on leaving protected mode must not itself raise a request
        base_delta = leave_prot ? '0 : snap_delta_q;
        base_pwr = leave_prot ? 1'b0 : snap_pwr_q;
        // total state compared with last signalled snapshot
        changed = (cur_delta != base_delta) || (pwr_now != base_pwr) || (int_d != snap_int_q);
        can_signal = !HOST_STOP && (state_q == DIU_IDLE);
        err_free = !ext_now && !int_d;
    end

    always_comb begin
        state_d = state_q;
        irq_d = irq_q;
        int_d = int_q | NVM_FAULT;
        prot_d = PROT_MODE;
        snap_delta_d = snap_delta_q;
        snap_pwr_d = snap_pwr_q;
        snap_int_d = snap_int_q;
        rec_delta_d = rec_delta_q;
        rec_pwr_d = rec_pwr_q;
        rec_int_d = rec_int_q;
        rec_group_d = rec_group_q;
        if (leave_prot) begin
            // external history dropped on leaving protected mode
            snap_delta_d = '0;
            snap_pwr_d = 1'b0;
            rec_delta_d = '0;
            rec_pwr_d = 1'b0;
        end
        unique case (state_q)
            DIU_IDLE: begin
                // snapshot cleared on exit from protected mode, so entry with an error
                // differs and fires; if deferred, it fires only if the error persists
                if (can_signal && changed) begin
                    state_d = DIU_PEND;
                    irq_d = 1'b1;
                    snap_delta_d = cur_delta;
                    snap_pwr_d = pwr_now;
                    snap_int_d = int_d;
                    rec_delta_d = cur_delta;
                    rec_pwr_d = pwr_now;
                    rec_int_d = int_d;
                    rec_group_d = !err_free;
                end
            end
            DIU_PEND: begin
                if (HOST_ACK) begin
                    state_d = DIU_IDLE;
                    irq_d = 1'b0;
                end
            end
            default: begin
                state_d = DIU_IDLE;
                irq_d = 1'b0;
            end
        endcase
        if (HOST_STOP) begin
            // stop wipes history; internal fault itself survives until reset
            state_d = DIU_IDLE;
            irq_d = 1'b0;
            snap_delta_d = '0;
            snap_pwr_d = 1'b0;
            snap_int_d = 1'b0;
            rec_delta_d = '0;
            rec_pwr_d = 1'b0;
            rec_int_d = 1'b0;
            rec_group_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= DIU_IDLE;
            irq_q <= 1'b0;
            int_q <= 1'b0;
            prot_q <= 1'b0;
            snap_delta_q <= '0;
            snap_pwr_q <= 1'b0;
            snap_int_q <= 1'b0;
            rec_delta_q <= '0;
            rec_pwr_q <= 1'b0;
            rec_int_q <= 1'b0;
            rec_group_q <= 1'b0;
        end else begin
            state_q <= state_d;
            irq_q <= irq_d;
            int_q <= int_d;
            prot_q <= prot_d;
            snap_delta_q <= snap_delta_d;
            snap_pwr_q <= snap_pwr_d;
            snap_int_q <= snap_int_d;
            rec_delta_q <= rec_delta_d;
            rec_pwr_q <= rec_pwr_d;
            rec_int_q <= rec_int_d;
            rec_group_q <= rec_group_d;
        end
    end

    // record images built from the signalled snapshot; the byte 2 offline bit follows HOST_STOP directly
    always_comb begin
        b0 = '0;
        b0[DIU_B0_GROUP] = rec_group_q;
        b0[DIU_B0_INT] = rec_int_q;
        b0[DIU_B0_EXT] = (|rec_delta_q) | rec_pwr_q;
        b0[DIU_B0_CFG] = |rec_delta_q;
        b0[DIU_B0_VOLT] = rec_pwr_q;
        b2 = '0;
        b2[DIU_B2_CFG] = |rec_delta_q;
        b2[DIU_B2_OFFLINE] = HOST_STOP;
        b3 = '0;
        b3[DIU_B3_NVM] = rec_int_q;
        basic_img = {b3, b2, DIU_B1_CLASS, b0};
        ext_img[0] = b0;
        ext_img[1] = DIU_B1_CLASS;
        ext_img[2] = b2;
        ext_img[3] = b3;
        ext_img[4] = DIU_X4;
        ext_img[5] = DIU_X5;
        ext_img[6] = DIU_X6;
        for (int i = DIU_DELTA_FIRST; i <= DIU_DELTA_LAST; i++) begin
            ext_img[i] = rec_delta_q[(i - DIU_DELTA_FIRST) * 8 +: 8];
        end
        ext_img[DIU_EXT_BYTES-1] = DIU_RSVD;
        data_d = ext_img[REC_INDEX];
        basic_d = basic_img;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            data_q <= '0;
            basic_q <= '0;
        end else begin
            data_q <= data_d;
            basic_q <= basic_d;
        end
    end

    assign DIAG_IRQ = irq_q;
    assign REC_DATA = data_q;
    assign BASIC_DIAG_RECORD = basic_q;

    // checks
    property p_irq_hold;
        @(posedge CLK) disable iff (RESET)
        (irq_q && !HOST_ACK && !HOST_STOP) |=> irq_q;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped before ack");

    property p_ack_drop;
        @(posedge CLK) disable iff (RESET)
        (irq_q && HOST_ACK) |=> !irq_q;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request not cleared by ack");

    property p_fire;
        @(posedge CLK) disable iff (RESET)
        (!HOST_STOP && state_q == DIU_IDLE && changed) |=> irq_q;
    endproperty
    a_fire: assert property (p_fire) else $error("change not signalled");

    property p_no_fire_same;
        @(posedge CLK) disable iff (RESET)
        (!irq_q && !changed) |=> !irq_q;
    endproperty
    a_no_fire_same: assert property (p_no_fire_same) else $error("interrupt without change");

    property p_stop_clear;
        @(posedge CLK) disable iff (RESET)
        HOST_STOP |=> (!rec_group_q && !irq_q && rec_delta_q == '0);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear history");

    property p_int_sticky;
        @(posedge CLK) disable iff (RESET)
        int_q |=> int_q;
    endproperty
    a_int_sticky: assert property (p_int_sticky) else $error("internal fault lost");

    property p_group_bit;
        @(posedge CLK) disable iff (RESET)
        $rose(irq_q) |-> (rec_group_q == (snap_int_q || snap_pwr_q || snap_delta_q != '0));
    endproperty
    a_group_bit: assert property (p_group_bit) else $error("group bit wrong on signal");

    property p_cfg_quiet;
        @(posedge CLK) disable iff (RESET)
        (!PROT_MODE && !NVM_FAULT && !int_q && snap_delta_q == '0 && !snap_pwr_q && !snap_int_q && !irq_q) |=> !irq_q;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("interrupt in config mode");

    property p_rec_bit0;
        @(posedge CLK) disable iff (RESET)
        ##1 (BASIC_DIAG_RECORD[DIU_B0_GROUP] == $past(rec_group_q));
    endproperty
    a_rec_bit0: assert property (p_rec_bit0) else $error("record bit 0 mismatch");

    sequence s_fire_cond;
        !HOST_STOP && state_q == DIU_IDLE && changed;
    endsequence

    sequence s_pending;
        irq_q && state_q == DIU_PEND;
    endsequence

    property p_fire_snapshot;
        @(posedge CLK) disable iff (RESET)
        s_fire_cond |=> s_pending ##0 (snap_delta_q == $past(cur_delta) && snap_pwr_q == $past(pwr_now));
    endproperty
    a_fire_snapshot: assert property (p_fire_snapshot) else $error("snapshot not taken on signal");

    property p_leave_quiet;
        @(posedge CLK) disable iff (RESET)
        (leave_prot && !irq_q && !NVM_FAULT && int_q == snap_int_q) |=>
            (!irq_q && snap_delta_q == '0 && !snap_pwr_q);
    endproperty
    a_leave_quiet: assert property (p_leave_quiet) else $error("leaving protected mode signalled");

    property p_enter_err;
        @(posedge CLK) disable iff (RESET)
        (!prot_q && PROT_MODE && (|delta_now) && !HOST_STOP && state_q == DIU_IDLE) |=> s_pending;
    endproperty
    a_enter_err: assert property (p_enter_err) else $error("entry with error not signalled");

    property p_defer_hold;
        @(posedge CLK) disable iff (RESET)
        (state_q == DIU_PEND && !HOST_ACK && !HOST_STOP && !leave_prot) |=>
            ($stable(snap_delta_q) && $stable(snap_pwr_q) && $stable(snap_int_q));
    endproperty
    a_defer_hold: assert property (p_defer_hold) else $error("snapshot moved while pending");

    property p_int_entering;
        @(posedge CLK) disable iff (RESET)
        (int_q && $rose(irq_q)) |-> rec_group_q;
    endproperty
    a_int_entering: assert property (p_int_entering) else $error("internal fault signalled leaving");

    property p_delta_byte;
        @(posedge CLK) disable iff (RESET)
        (REC_INDEX == 4'(DIU_DELTA_FIRST)) |=> (REC_DATA == $past(rec_delta_q[7:0]));
    endproperty
    a_delta_byte: assert property (p_delta_byte) else $error("first delta byte mismatch");
endmodule : diu_top

/* verilog/diu_pkg.sv */
// diu_pkg: constants, record layouts and states of the diagnostic interrupt unit
// assumes a single 25 MHz clock; record bytes are read by index from the host side
package diu_pkg;
    localparam int DIU_SLAVES = 64;
    localparam int DIU_EXT_BYTES = 16;
    localparam int DIU_IDX_W = 4;
    // basic record byte 0 bit positions
    localparam int DIU_B0_GROUP = 0;
    localparam int DIU_B0_INT = 1;
    localparam int DIU_B0_EXT = 2;
    localparam int DIU_B0_CFG = 3;
    localparam int DIU_B0_VOLT = 4;
    // byte 1 holds module class and a fixed one
    localparam logic [7:0] DIU_B1_CLASS = 8'h1C;
    // byte 2 bit positions
    localparam int DIU_B2_CFG = 0;
    localparam int DIU_B2_OFFLINE = 2;
    // byte 3 bit position
    localparam int DIU_B3_NVM = 2;
    // extended record fixed bytes and delta list start
    localparam logic [7:0] DIU_X4 = 8'h60;
    localparam logic [7:0] DIU_X5 = 8'h00;
    localparam logic [7:0] DIU_X6 = 8'h40;
    localparam int DIU_DELTA_FIRST = 7;
    localparam int DIU_DELTA_LAST = 14;
    localparam logic [7:0] DIU_RSVD = 8'h00;
    typedef enum logic [1:0] {DIU_IDLE, DIU_PEND} diu_state_t;
endpackage : diu_pkg

/* verification/diu_host_model.sv */
// diu_host_model: host cpu side of the diagnostic interrupt
// assumes irq held until ack, basic record valid a cycle after irq
`timescale 1ns/10ps
module diu_host_model #(
    parameter int DELAY = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    input wire logic [31:0] basic,
    output logic ack,
    output logic [7:0] seen_b0
);
    int cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            cnt <= 0;
            seen_b0 <= 8'h00;
        end else begin
            ack <= 1'b0;
            if (irq && !ack) begin
                cnt <= cnt + 1;
                // record read first, handler runs after
                if (cnt == 2) seen_b0 <= basic[7:0];
                if (cnt == DELAY) begin
                    ack <= 1'b1;
                    cnt <= 0;
                end
            end else if (!irq) begin
                // a request withdrawn early must not leave a stale count
                cnt <= 0;
            end
        end
    end
endmodule : diu_host_model

/* verification/test_diu_top.sv */
// test_diu_top: self-checking bench for diu_top against a state model
// assumes host model acks well after records settle
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_diu_top
    import diu_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, stop = 1'b0, ack, prot = 1'b1, pf = 1'b0, nvm = 1'b0, irq;
    logic [63:0] miss = '0, wt = '0, unc = '0;
    logic [3:0] idx = 4'h0;
    logic [7:0] rdata, seen_b0;
    logic [31:0] basic;
    logic [65:0] snap = '0;
    logic nvm_l = 1'b0;
    int error_cnt = 0, n_compared = 0, r, k;
    always #20 clk = ~clk;
    diu_top dut (.CLK(clk), .RESET(rst), .HOST_STOP(stop), .HOST_ACK(ack), .PROT_MODE(prot),
        .LINE_POWER_FAIL(pf), .NVM_FAULT(nvm), .SLAVE_MISSING(miss), .SLAVE_WRONG_TYPE(wt),
        .SLAVE_UNCONFIG(unc), .REC_INDEX(idx), .DIAG_IRQ(irq), .REC_DATA(rdata), .BASIC_DIAG_RECORD(basic));
    diu_host_model host (.clk(clk), .rst(rst), .irq(irq), .basic(basic), .ack(ack), .seen_b0(seen_b0));
    // config mode masks external state; internal fault latched
    function automatic logic [65:0] cur_state();
        return {prot ? (miss | wt | unc) : 64'h0, prot & pf, nvm_l};
    endfunction : cur_state
    task automatic apply(input logic s, p, f, n, input logic [63:0] m, w, u);
        @(posedge clk);
        if (s && !stop) snap = '0;
        if (prot && !p) snap[65:1] = '0;
        if (n) nvm_l = 1'b1;
        stop <= s;
        prot <= p;
        pf <= f;
        nvm <= n;
        miss <= m;
        wt <= w;
        unc <= u;
        @(posedge clk);
    endtask : apply
    task automatic settle(input int slv);
        logic [65:0] st;
        logic exp;
        st = cur_state();
        exp = !stop && st != snap;
        repeat (3) @(posedge clk);
        idx <= 4'(DIU_DELTA_FIRST + slv / 8);
        #1 `CHK(irq, exp)
        if (exp) begin
            snap = st;
            `CHK(basic[DIU_B0_GROUP], st != 0)
            `CHK(basic[DIU_B0_CFG], |st[65:2])
            `CHK(basic[DIU_B0_VOLT], st[1])
            `CHK(basic[DIU_B0_INT], st[0])
            `CHK(basic[DIU_B0_EXT], |st[65:1])
            `CHK(basic[15:8], DIU_B1_CLASS)
            `CHK(basic[16 + DIU_B2_CFG], |st[65:2])
            `CHK(basic[24 + DIU_B3_NVM], st[0])
            repeat (2) @(posedge clk);
            #1 `CHK(rdata, st[2 + (slv / 8) * 8 +: 8])
            `CHK(irq, 1'b1)
        end
        for (k = 0; k < 30 && irq !== 1'b0; k++) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        if (exp) `CHK(seen_b0[0], st != 0)
    endtask : settle
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        r = $urandom(32'h4d6c);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apply(0, 1, 0, 0, 64'h8, 0, 0); settle(3);
        r = $urandom_range(63);
        apply(0, 1, 0, 0, 64'h8, 64'h1 << r, 0); settle(r);
        r = $urandom_range(63);
        apply(0, 1, 0, 0, 0, 0, 64'h1 << r); settle(r);
        @(posedge clk);
        idx <= 4'h4;
        repeat (2) @(posedge clk);
        #1 `CHK(rdata, DIU_X4)
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        apply(0, 1, 1, 0, 0, 0, 0); settle(0);
        apply(0, 0, 1, 0, 64'h8, 0, 0); settle(3);
        apply(0, 0, 1, 0, 64'h18, 0, 0); settle(3);
        apply(0, 1, 1, 0, 64'h18, 0, 0); settle(3);
        apply(0, 0, 0, 0, 64'h8, 0, 0); settle(3);
        apply(1, 0, 0, 0, 64'h8, 0, 0); settle(3);
        `CHK(basic[7:0], 8'h00)
        `CHK(basic[16 + DIU_B2_OFFLINE], 1'b1)
        apply(1, 1, 0, 0, 64'h8, 0, 0);
        apply(1, 1, 0, 0, 0, 0, 0);
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        apply(1, 1, 0, 0, 64'h100, 0, 0);
        apply(0, 1, 0, 0, 64'h100, 0, 0); settle(8);
        apply(1, 1, 0, 0, 64'h4, 0, 0);
        apply(1, 1, 0, 0, 0, 0, 0);
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        // transient while the request is pending, back to the signalled state before ack
        apply(0, 1, 0, 0, 64'h2, 0, 0);
        apply(0, 1, 0, 0, 64'h6, 0, 0);
        apply(0, 1, 0, 0, 64'h2, 0, 0); settle(1);
        settle(1);
        apply(0, 1, 0, 1, 0, 0, 0); settle(0);
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        apply(1, 1, 0, 0, 0, 0, 0);
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        // restart clears the latched internal fault
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        snap = '0;
        nvm_l = 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK(basic, {16'h0000, DIU_B1_CLASS, 8'h00})
        apply(0, 1, 0, 0, 0, 0, 0); settle(0);
        repeat (6) begin
            r = $urandom_range(63);
            apply(0, 1, 1'($urandom), 0, 64'h1 << r, 0, 0); settle(r);
        end
        report_and_stop();
    end
endmodule : test_diu_top
